// [src/mcr_pkg.sv]
package mcr_pkg;

  localparam int ADDR_W = 8;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ZERO_WAIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DRIVER_CONFIG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SILENT_PWM_THR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_HIGH_VEL_THR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LOAD_ADAPT_THR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STEP_INTERVAL = 8'h1c;

  // ==========================================================
  // field positions
  localparam int POS_HOLD_SCALE = 0;
  localparam int POS_RUN_SCALE = 8;
  localparam int POS_DOWN_DELAY = 16;
  localparam int POS_UP_DELAY = 24;
  localparam int POS_RANGE = 0;
  localparam int POS_PWM_EN = 4;
  localparam int POS_ADAPT_EN = 5;
  localparam int POS_HYST_FINE = 6;
  localparam int POS_MRES = 8;
  localparam int POS_ST_SCALE = 0;
  localparam int POS_ST_STANDSTILL = 8;
  localparam int POS_ST_PWM = 9;
  localparam int POS_ST_ADAPT = 10;
  localparam int POS_ST_RAMP = 12;
  localparam int POS_ST_KFS = 16;

  // ==========================================================
  // write masks and reset values
  localparam logic [31:0] MASK_CURRENT = 32'h0f0f_1f1f;
  localparam logic [31:0] MASK_ZERO_WAIT = 32'h0000_00ff;
  localparam logic [31:0] MASK_DRIVER_CONFIG = 32'h0000_0f73;
  localparam logic [31:0] MASK_THR = 32'h000f_ffff;
  localparam logic [31:0] RST_CURRENT = 32'h0401_1f08;
  localparam logic [31:0] RST_ZERO_WAIT = 32'h0000_0014;
  localparam logic [31:0] RST_DRIVER_CONFIG = 32'h0000_0000;
  localparam logic [19:0] RST_THR = 20'h0_0000;

  // ==========================================================
  // timing
  localparam int STANDSTILL_CYCLES_DEF = 1 << 20;
  localparam int HOLD_UNIT_CYCLES_DEF = 1 << 18;
  localparam logic [26:0] UP_UNIT_CYCLES = 27'h000_0200;
  localparam logic [19:0] INTERVAL_MAX = 20'hf_ffff;
  localparam logic [3:0] MRES_MAX = 4'h8;

  // full-scale constant in quarter units: 36, 24, 11.75
  localparam logic [7:0] KFS_36 = 8'h90;
  localparam logic [7:0] KFS_24 = 8'h60;
  localparam logic [7:0] KFS_11_75 = 8'h2f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    RAMP_RUN = 4'h1,
    RAMP_WAIT = 4'h2,
    RAMP_DOWN = 4'h4,
    RAMP_UP = 4'h8
  } mcr_ramp_type;

  typedef struct packed {
    logic [4:0] current_scale;
    logic standstill;
    logic silent_pwm_enable;
    logic load_adapt_enable;
    logic [7:0] full_scale_constant;
  } mcr_drive_type;

endpackage

// [src/mcr_current_ramp.sv]
`timescale 1ns/100ps
module mcr_current_ramp #(
  parameter int STANDSTILL_CYCLES = mcr_pkg::STANDSTILL_CYCLES_DEF,
  parameter int HOLD_UNIT_CYCLES = mcr_pkg::HOLD_UNIT_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [mcr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [mcr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic step_in,
  output mcr_pkg::mcr_drive_type drive
);
  import mcr_pkg::*;

  typedef struct packed {
    logic [1:0] sync;
    logic step_d;
    logic [19:0] step_cnt;
    logic [20:0] idle_cnt;
    logic [19:0] interval;
    mcr_ramp_type ramp;
    logic [26:0] tmr;
    logic [2:0] fast;
    logic [31:0] cur;
    logic [31:0] zwait;
    logic [31:0] drv;
    logic [2:0][19:0] thr;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstr;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    mcr_drive_type drive;
  } mcr_state_type;

  mcr_state_type s_r;
  mcr_state_type s_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res & mask;
  endfunction

  // ==========================================================
  // configuration fields
  logic [4:0] hold_scale;
  logic [4:0] run_scale;
  logic [3:0] down_delay;
  logic [3:0] up_delay;
  logic [3:0] mres;
  logic hyst_fine;
  logic [26:0] wait_target;
  logic [26:0] down_target;
  logic [26:0] up_target;
  logic step_edge;
  logic [2:0] fast_now;
  logic window;

  assign hold_scale = s_r.cur[POS_HOLD_SCALE +: 5];
  assign run_scale = s_r.cur[POS_RUN_SCALE +: 5];
  assign down_delay = s_r.cur[POS_DOWN_DELAY +: 4];
  assign up_delay = s_r.cur[POS_UP_DELAY +: 4];
  assign hyst_fine = s_r.drv[POS_HYST_FINE];
  assign mres = (s_r.drv[POS_MRES +: 4] > MRES_MAX) ? MRES_MAX : s_r.drv[POS_MRES +: 4];
  // the products fit: 255 x 2^18 and 15 x 2^18 stay below 2^27
  assign wait_target = 27'(s_r.zwait[7:0]) * 27'(HOLD_UNIT_CYCLES);
  assign down_target = 27'(down_delay) * 27'(HOLD_UNIT_CYCLES);
  assign up_target = 27'(up_delay) * UP_UNIT_CYCLES;
  // only the second synchroniser stage and its delayed copy feed the edge detector
  assign step_edge = s_r.sync[1] & ~s_r.step_d;

  // ==========================================================
  // threshold comparators with hysteresis
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_thr
      logic [20:0] thr_eff;
      logic [20:0] thr_lo;
      // the load-adapt window is inclusive of its threshold, the others are not
      assign thr_eff = {1'b0, s_r.thr[g]} + ((g == 2) ? 21'h00_0001 : 21'h00_0000);
      assign thr_lo = thr_eff - (hyst_fine ? (thr_eff >> 5) : (thr_eff >> 4));
      always_comb begin
        if (s_r.fast[g]) begin
          fast_now[g] = ({1'b0, s_r.interval} < thr_eff);
        end else begin
          fast_now[g] = ({1'b0, s_r.interval} < thr_lo);
        end
      end
    end
  endgenerate

  assign window = s_r.fast[2] & ~s_r.fast[1];

  // ==========================================================
  // next state
  always_comb begin
    logic wr_go;
    logic [31:0] rd;
    logic rd_ok;
    logic standstill;
    wr_go = 1'b0;
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    standstill = 1'b0;
    s_nxt = s_r;

    // step input and interval measurement
    s_nxt.sync = {s_r.sync[0], step_in};
    s_nxt.step_d = s_r.sync[1];
    if (step_edge) begin
      // the edge cycle itself is the first clock of the new gap
      s_nxt.step_cnt = 20'h0_0001;
      s_nxt.idle_cnt = 21'h00_0000;
      if (s_r.step_cnt == INTERVAL_MAX) begin
        s_nxt.interval = INTERVAL_MAX;
      end else begin
        s_nxt.interval = s_r.step_cnt >> mres;
      end
    end else begin
      if (s_r.step_cnt != INTERVAL_MAX) begin
        s_nxt.step_cnt = s_r.step_cnt + 20'h0_0001;
      end else begin
        s_nxt.interval = INTERVAL_MAX;
      end
      if (s_r.idle_cnt != 21'(STANDSTILL_CYCLES)) begin
        s_nxt.idle_cnt = s_r.idle_cnt + 21'h00_0001;
      end
    end
    standstill = (s_r.idle_cnt == 21'(STANDSTILL_CYCLES));
    if (standstill) begin
      s_nxt.interval = INTERVAL_MAX;
    end
    s_nxt.fast = fast_now;

    // current ramp
    s_nxt.tmr = s_r.tmr + 27'h000_0001;
    unique case (s_r.ramp)
      RAMP_RUN: begin
        s_nxt.drive.current_scale = run_scale;
        if (standstill) begin
          s_nxt.ramp = RAMP_WAIT;
          s_nxt.tmr = 27'h000_0000;
        end
      end
      RAMP_WAIT: begin
        if (!standstill) begin
          s_nxt.ramp = RAMP_UP;
          s_nxt.tmr = 27'h000_0000;
        end else if (s_r.tmr >= wait_target) begin
          s_nxt.ramp = RAMP_DOWN;
          s_nxt.tmr = 27'h000_0000;
        end
      end
      RAMP_DOWN: begin
        if (!standstill) begin
          s_nxt.ramp = RAMP_UP;
          s_nxt.tmr = 27'h000_0000;
        end else if (s_r.drive.current_scale <= hold_scale || down_delay == 4'h0) begin
          s_nxt.drive.current_scale = hold_scale;
          s_nxt.tmr = 27'h000_0000;
        end else if (s_r.tmr + 27'h000_0001 >= down_target) begin
          s_nxt.drive.current_scale = s_r.drive.current_scale - 5'h01;
          s_nxt.tmr = 27'h000_0000;
        end
      end
      RAMP_UP: begin
        if (standstill) begin
          s_nxt.ramp = RAMP_WAIT;
          s_nxt.tmr = 27'h000_0000;
        end else if (s_r.drive.current_scale >= run_scale || up_delay == 4'h0) begin
          s_nxt.drive.current_scale = run_scale;
          s_nxt.ramp = RAMP_RUN;
        end else if (s_r.tmr + 27'h000_0001 >= up_target) begin
          s_nxt.drive.current_scale = s_r.drive.current_scale + 5'h01;
          s_nxt.tmr = 27'h000_0000;
        end
      end
    endcase

    // mode outputs
    s_nxt.drive.standstill = standstill;
    s_nxt.drive.load_adapt_enable = s_r.drv[POS_ADAPT_EN] & window;
    s_nxt.drive.silent_pwm_enable = s_r.drv[POS_PWM_EN] & ~s_r.fast[0] & ~window;
    unique case (s_r.drv[POS_RANGE +: 2])
      2'b11, 2'b10: s_nxt.drive.full_scale_constant = KFS_36;
      2'b01: s_nxt.drive.full_scale_constant = KFS_24;
      2'b00: s_nxt.drive.full_scale_constant = KFS_11_75;
    endcase

    // write channel: address and data taken in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.waddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wready = 1'b0;
      s_nxt.wdat = wdata;
      s_nxt.wstr = wstrb;
    end
    wr_go = s_r.aw_hold & s_r.w_hold & ~s_r.bvalid;
    if (wr_go) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (s_r.waddr)
        OFS_CURRENT: s_nxt.cur = merge(s_r.cur, s_r.wdat, s_r.wstr, MASK_CURRENT);
        OFS_ZERO_WAIT: s_nxt.zwait = merge(s_r.zwait, s_r.wdat, s_r.wstr, MASK_ZERO_WAIT);
        OFS_DRIVER_CONFIG: begin
          s_nxt.drv = merge(s_r.drv, s_r.wdat, s_r.wstr, MASK_DRIVER_CONFIG);
        end
        OFS_SILENT_PWM_THR: begin
          s_nxt.thr[0] = 20'(merge({12'h000, s_r.thr[0]}, s_r.wdat, s_r.wstr, MASK_THR));
        end
        OFS_HIGH_VEL_THR: begin
          s_nxt.thr[1] = 20'(merge({12'h000, s_r.thr[1]}, s_r.wdat, s_r.wstr, MASK_THR));
        end
        OFS_LOAD_ADAPT_THR: begin
          s_nxt.thr[2] = 20'(merge({12'h000, s_r.thr[2]}, s_r.wdat, s_r.wstr, MASK_THR));
        end
        OFS_STATUS, OFS_STEP_INTERVAL: s_nxt.bresp = RESP_OKAY;
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // read channel
    case (araddr)
      OFS_CURRENT: rd = s_r.cur;
      OFS_ZERO_WAIT: rd = s_r.zwait;
      OFS_DRIVER_CONFIG: rd = s_r.drv;
      OFS_SILENT_PWM_THR: rd = {12'h000, s_r.thr[0]};
      OFS_HIGH_VEL_THR: rd = {12'h000, s_r.thr[1]};
      OFS_LOAD_ADAPT_THR: rd = {12'h000, s_r.thr[2]};
      OFS_STATUS: begin
        rd[POS_ST_SCALE +: 5] = s_r.drive.current_scale;
        rd[POS_ST_STANDSTILL] = s_r.drive.standstill;
        rd[POS_ST_PWM] = s_r.drive.silent_pwm_enable;
        rd[POS_ST_ADAPT] = s_r.drive.load_adapt_enable;
        rd[POS_ST_RAMP +: 4] = s_r.ramp;
        rd[POS_ST_KFS +: 8] = s_r.drive.full_scale_constant;
      end
      OFS_STEP_INTERVAL: rd = {12'h000, s_r.interval};
      default: rd_ok = 1'b0;
    endcase
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ramp <= RAMP_RUN;
      s_r.cur <= RST_CURRENT;
      s_r.zwait <= RST_ZERO_WAIT;
      s_r.drv <= RST_DRIVER_CONFIG;
      s_r.thr <= {RST_THR, RST_THR, RST_THR};
      s_r.interval <= INTERVAL_MAX;
      s_r.step_cnt <= INTERVAL_MAX;
      s_r.drive.current_scale <= RST_CURRENT[POS_RUN_SCALE +: 5];
      s_r.drive.full_scale_constant <= KFS_11_75;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign drive = s_r.drive;

endmodule

// [testbench/mcr_monitor.sv]
`timescale 1ns/100ps
module mcr_monitor #(
  parameter int STANDSTILL_CYCLES = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic step_in,
  input wire mcr_pkg::mcr_drive_type drive
);
  import mcr_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // cycles since the step line was last high
  // eight bits only: sized for a shortened standstill count
  logic [7:0] idle_r;
  logic [7:0] idle_nxt;
  always_comb begin
    idle_nxt = idle_r;
    if (step_in) idle_nxt = 8'h00;
    else if (idle_r != 8'hff) idle_nxt = idle_r + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) idle_r <= 8'h00;
    else idle_r <= idle_nxt;
  end
  // ==========================================================
  // properties
  sequence s_both_taken; awvalid && awready && wvalid && wready; endsequence
  sequence s_b_answer; !bvalid ##1 bvalid; endsequence
  property p_b_lat; s_both_taken |=> s_b_answer; endproperty
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_r_lat; arvalid && arready |=> rvalid; endproperty
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_aw_wait; bvalid |-> !awready && !wready; endproperty
  property p_still_up; idle_r == STANDSTILL_CYCLES + 10 |-> drive.standstill; endproperty
  property p_still_low;
    idle_r >= 10 && idle_r < STANDSTILL_CYCLES - 4 |-> !drive.standstill;
  endproperty
  property p_modes_apart; !(drive.silent_pwm_enable && drive.load_adapt_enable); endproperty
  // the idle guard skips the lag of the flag behind the step line
  property p_hold_fall;
    drive.standstill && $past(drive.standstill) && idle_r >= 8
      |-> drive.current_scale <= $past(drive.current_scale);
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer timing");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_lat: assert property (p_r_lat) else $error("read answer timing");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_aw_wait: assert property (p_aw_wait) else $error("accepts while answer pending");
  a_still_up: assert property (p_still_up) else $error("standstill missing");
  a_still_low: assert property (p_still_low) else $error("standstill early");
  a_modes_apart: assert property (p_modes_apart) else $error("both modes on");
  a_hold_fall: assert property (p_hold_fall) else $error("scale rose at rest");
endmodule

// [testbench/mcr_step_source.sv]
`timescale 1ns/100ps
module mcr_step_source (
  input wire logic aclk,
  input wire logic run,
  input wire logic [15:0] period,
  output logic step_out
);
  int cnt = 0;
  initial step_out = 1'b0;
  // pulse lasts two clocks so the two-stage input sync cannot miss it
  always @(posedge aclk) begin
    cnt <= (!run || cnt + 1 >= period) ? 0 : cnt + 1;
    step_out <= run && cnt < 2;
  end
endmodule

// [testbench/mcr_current_ramp_tb.sv]
`timescale 1ns/100ps
module mcr_current_ramp_tb;
  import mcr_pkg::*;
  typedef struct packed {
    logic [11:0] cfg;
    logic [15:0] per;
    logic [19:0] iv;
    logic pwm;
    logic adapt;
    logic [7:0] kfs;
  } mcr_row_type;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, step_in, run;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] period;
  mcr_drive_type drv;
  mcr_row_type rows [6];
  int err_total = 0;
  int compares = 0;
  int g;
  mcr_current_ramp #(.STANDSTILL_CYCLES(200), .HOLD_UNIT_CYCLES(4)) mcr_current_ramp_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .step_in, .drive(drv));
  mcr_step_source mcr_step_source_i (.aclk, .run, .period, .step_out(step_in));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // cycles until the scale next changes
  task automatic gap(output int n);
    logic [4:0] s;
    s = drv.current_scale;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (drv.current_scale === s && n < 20000);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    run = 1'b0;
    period = 16'd100;
    // thresholds: silent pwm 160, high velocity 64, load adapt 100
    rows = '{'{12'h030, 16'd176, 20'd176, 1'b1, 1'b0, 8'h2f},
             '{12'h131, 16'd160, 20'd80, 1'b0, 1'b1, 8'h60},
             '{12'h032, 16'd128, 20'd128, 1'b0, 1'b0, 8'h90},
             '{12'h133, 16'd128, 20'd64, 1'b0, 1'b1, 8'h90},
             '{12'h170, 16'd122, 20'd61, 1'b0, 1'b0, 8'h2f},
             '{12'h021, 16'd176, 20'd176, 1'b0, 1'b0, 8'h60}};
    rst();
    wr(OFS_SILENT_PWM_THR, 32'd160);
    wr(OFS_HIGH_VEL_THR, 32'd64);
    wr(OFS_LOAD_ADAPT_THR, 32'd100);
    foreach (rows[i]) begin
      wr(OFS_DRIVER_CONFIG, {20'h0, rows[i].cfg});
      period <= rows[i].per;
      run <= 1'b1;
      repeat (700) @(posedge aclk);
      rd_reg(OFS_STEP_INTERVAL);
      chk(rd, {12'h0, rows[i].iv});
      rd_reg(OFS_STATUS);
      chk(rd[23:16], rows[i].kfs);
      chk(drv.full_scale_constant, rows[i].kfs);
      chk(drv.silent_pwm_enable, rows[i].pwm);
      chk(drv.load_adapt_enable, rows[i].adapt);
    end
    run <= 1'b0;
    rst();
    chk(drv.current_scale, 5'd31);
    chk(drv.full_scale_constant, 8'h2f);
    rd_reg(OFS_CURRENT);
    chk(rd, 32'h0401_1f08);
    while (drv.standstill !== 1'b1) @(posedge aclk);
    repeat (300) @(posedge aclk);
    chk(drv.current_scale, 5'd8);
    wr(OFS_ZERO_WAIT, 32'h1);
    wr(OFS_CURRENT, 32'h0102_1404);
    run <= 1'b1;
    // the first change may be a late power-down step, so skip two changes
    gap(g);
    gap(g);
    gap(g);
    chk(g, 512);
    repeat (9000) @(posedge aclk);
    chk(drv.current_scale, 5'd20);
    run <= 1'b0;
    gap(g);
    gap(g);
    chk(g, 8);
    repeat (200) @(posedge aclk);
    chk(drv.current_scale, 5'd4);
    wr(OFS_CURRENT, 32'h0000_1404);
    run <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(drv.current_scale, 5'd20);
    run <= 1'b0;
    gap(g);
    chk(drv.current_scale, 5'd4);
    // read-only target ignores a write; unmapped place refuses
    wr(OFS_STEP_INTERVAL, 32'h0);
    chk(rsp, RESP_OKAY);
    rd_reg(8'h20);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    end_sim();
  end
endmodule
bind mcr_current_ramp mcr_monitor #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES)) mcr_monitor_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .step_in, .drive);
